/* core/sesao_top.sv */
// Serial EEPROM status register, write protection and opcode interpreter
//
// Notes on behaviour
// - Status register read-only while hardware protection active or write latch clear.
// - Status bit 0 is busy; while busy only status read is accepted.
// - Write latch in bit 1, cleared at power-up, zero refuses every change.
// - Protect selects in bits 2 and 3, kept, starting cleared.
// - Block protection applies regardless of arm bit, protect pin or latch.
// - Selection 00 none, 01 3000h-3FFFh, 10 2000h-3FFFh, 11 everything.
// - Status bits 4 to 6 are not stored and read zero when idle.
// - Arm in bit 7; pin low plus arm locks status, not array.
// - Arm cannot go from 1 to 0 while protect pin is low.
// - During an internal write cycle status reads as all ones.
// - Select low starts an instruction; input sampled on each rising clock.
// - After the opcode capture address or data, or shift out on falling edges.
// - Every opcode, address and data byte travels most significant bit first.
// - Select rises after the last bit to end and start the operation.
// - 0000X110 sets write latch, 0000X100 clears it, no address or data.
// - 0000X101 reads eight status bits, 0000X001 writes status with one byte.
// - 0000X011 array read, 0000X010 array write, each with 16-bit address.
// - 1000X011 ID page read, 1000X010 ID page write, with address and data.
// - Lock status read and lock share 1000X010, told apart by data bit 1.
// - ID page instructions need address bit 10 at zero.
// - Lock status and lock instructions need address bit 10 at one.
// - Write latch clears when latch-clear completes or any status, array, ID page or lock write cycle ends.
module sesao_top
	import sesao_pkg::*;
#(
	parameter int unsigned WRITE_CYCLES = WRITE_CYCLE_CYCLES
) (
	input  wire logic        i_clk,
	input  wire logic        i_reset,
	input  wire logic        i_sck,
	input  wire logic        i_cs_n,
	input  wire logic        i_si,
	input  wire logic        i_protect_pin_n,
	output logic             o_so,
	output logic             o_so_oe,
	output logic [7:0]       o_status,
	output logic             o_hw_protect,
	output logic             o_array_write_go,
	output logic             o_idpage_write_go,
	output logic [15:0]      o_write_addr
);

	sesao_link_s l_r;
	sesao_link_s l_nxt;
	sesao_core_s c_r;
	sesao_core_s c_nxt;
	logic        armed_r;
	logic        so_r;
	logic        so_oe_r;
	sesao_op_e   lnk_cls;
	logic        lnk_reading;
	logic [7:0]  lnk_out_byte;

	// Link side: runs on the serial clock, which stands still between frames

	// Set by select high, so the first rising edge of a frame restarts the counters
	always_ff @(posedge i_sck or posedge i_cs_n) begin
		if (i_cs_n) begin
			armed_r <= 1'b1;
		end else begin
			armed_r <= 1'b0;
		end
	end

	always_comb begin
		logic [7:0]  sh;
		logic [2:0]  b_ph;
		logic [2:0]  b_nb;
		sesao_lnk_e  b_st;
		logic        byte_done;
		sesao_op_e   cls;
		sh        = 8'h00;
		b_ph      = 3'h0;
		b_nb      = 3'h0;
		b_st      = LNK_OPCODE;
		byte_done = 1'b0;
		cls       = OPC_INVALID;
		l_nxt     = l_r;
		b_ph      = armed_r ? 3'h0 : l_r.bitph;
		b_nb      = armed_r ? 3'h0 : l_r.nbytes;
		b_st      = armed_r ? LNK_OPCODE : l_r.state;
		sh        = {l_r.data[6:0], i_si};
		byte_done = (b_ph == 3'h7);
		l_nxt.bitph  = b_ph + 3'h1;
		l_nxt.nbytes = b_nb;
		l_nxt.state  = b_st;
		l_nxt.data   = armed_r ? {7'h00, i_si} : sh;
		if (byte_done && b_nb != 3'h7) begin
			l_nxt.nbytes = b_nb + 3'h1;
		end
		case (b_st)
			LNK_OPCODE: begin
				if (byte_done) begin
					l_nxt.opcode = sh;
					cls = sesao_decode(sh);
					case (cls)
						OPC_RD_ARR, OPC_WR_ARR, OPC_RD_ID, OPC_WR_ID: l_nxt.state = LNK_ADDR;
						OPC_INVALID: l_nxt.state = LNK_IGNORE;
						default:     l_nxt.state = LNK_DATA;
					endcase
				end
			end
			LNK_ADDR: begin
				l_nxt.addr = {l_r.addr[14:0], i_si};
				if (byte_done && b_nb == 3'h2) begin
					l_nxt.state = LNK_DATA;
				end
			end
			LNK_DATA: begin
			end
			LNK_IGNORE: begin
				l_nxt.state = LNK_IGNORE;
			end
			default: begin
				l_nxt.state = LNK_IGNORE;
			end
		endcase
	end

	// No reset here: a frame always restarts through the armed flag
	always_ff @(posedge i_sck) begin
		l_r <= l_nxt;
	end

	// Status view is held still by the core while selected; the lock bit can change when a busy period ends
	always_comb begin
		lnk_cls      = sesao_decode(l_r.opcode);
		lnk_reading  = 1'b0;
		lnk_out_byte = READ_FILL;
		case (lnk_cls)
			OPC_RD_ST: begin
				lnk_reading  = 1'b1;
				lnk_out_byte = c_r.view;
			end
			OPC_RD_ARR, OPC_RD_ID: begin
				lnk_reading  = 1'b1;
				lnk_out_byte = READ_FILL;
			end
			OPC_WR_ID: begin
				lnk_reading  = l_r.addr[ADDR_SEL_BIT];
				lnk_out_byte = {7'h00, c_r.lock};
			end
			default: begin
				lnk_reading  = 1'b0;
				lnk_out_byte = READ_FILL;
			end
		endcase
	end

	// Falling-edge launch gives the controller a half period of setup
	always_ff @(negedge i_sck or posedge i_cs_n) begin
		if (i_cs_n) begin
			so_r    <= 1'b0;
			so_oe_r <= 1'b0;
		end else if (!armed_r && l_r.state == LNK_DATA && lnk_reading) begin
			so_r    <= lnk_out_byte[~l_r.bitph];
			so_oe_r <= 1'b1;
		end else begin
			so_r    <= 1'b0;
			so_oe_r <= 1'b0;
		end
	end

	assign o_so    = so_r;
	assign o_so_oe = so_oe_r;

	// Core side: system clock, acts once select has risen

	always_comb begin
		logic      end_frame;
		logic      boundary;
		logic      hwp;
		sesao_op_e cls;
		end_frame = 1'b0;
		boundary  = 1'b0;
		hwp       = 1'b0;
		cls       = OPC_INVALID;
		c_nxt     = c_r;
		c_nxt.cs_s1 = i_cs_n;
		c_nxt.cs_s2 = c_r.cs_s1;
		c_nxt.cs_s3 = c_r.cs_s2;
		c_nxt.wp_s1 = i_protect_pin_n;
		c_nxt.wp_s2 = c_r.wp_s1;
		c_nxt.array_go = 1'b0;
		c_nxt.id_go    = 1'b0;
		hwp = !c_r.wp_s2 && c_r.arm;
		c_nxt.hw_protect = hwp;
		// Link fields are read only here, while the serial clock is idle
		end_frame = c_r.cs_s2 && !c_r.cs_s3;
		boundary  = (l_r.bitph == 3'h0);
		cls       = sesao_decode(l_r.opcode);
		if (c_r.busy) begin
			if (c_r.timer == 16'h0000) begin
				c_nxt.busy        = 1'b0;
				c_nxt.latch       = 1'b0;
				c_nxt.pend_status = 1'b0;
				c_nxt.pend_lock   = 1'b0;
				if (c_r.pend_status) begin
					c_nxt.sel_lo = c_r.new_status[ST_SEL_LO_BIT];
					c_nxt.sel_hi = c_r.new_status[ST_SEL_HI_BIT];
					c_nxt.arm    = c_r.new_status[ST_ARM_BIT];
				end
				if (c_r.pend_lock) begin
					c_nxt.lock = 1'b1;
				end
			end else begin
				c_nxt.timer = c_r.timer - 16'h0001;
			end
		end else if (end_frame) begin
			// Busy frames never reach here, so only status reads work then
			case (cls)
				OPC_SET_WL: begin
					if (l_r.nbytes == 3'h1 && boundary) begin
						c_nxt.latch = 1'b1;
					end
				end
				OPC_CLR_WL: begin
					if (l_r.nbytes == 3'h1 && boundary) begin
						c_nxt.latch = 1'b0;
					end
				end
				OPC_WR_ST: begin
					// Pin low with arm set refuses the whole write, so arm stays 1
					if (l_r.nbytes == 3'h2 && boundary && c_r.latch && !hwp) begin
						c_nxt.new_status  = l_r.data;
						c_nxt.pend_status = 1'b1;
						c_nxt.busy        = 1'b1;
						c_nxt.timer       = 16'(WRITE_CYCLES - 1);
					end
				end
				OPC_WR_ARR: begin
					// Hardware protection does not cover the array
					if (l_r.nbytes >= 3'h4 && boundary && c_r.latch
						&& !sesao_prot_hit({c_r.sel_hi, c_r.sel_lo}, l_r.addr[13:0])) begin
						c_nxt.array_go = 1'b1;
						c_nxt.wr_addr  = l_r.addr;
						c_nxt.busy     = 1'b1;
						c_nxt.timer    = 16'(WRITE_CYCLES - 1);
					end
				end
				OPC_WR_ID: begin
					if (!l_r.addr[ADDR_SEL_BIT]) begin
						if (l_r.nbytes >= 3'h4 && boundary && c_r.latch && !c_r.lock) begin
							c_nxt.id_go   = 1'b1;
							c_nxt.wr_addr = l_r.addr;
							c_nxt.busy    = 1'b1;
							c_nxt.timer   = 16'(WRITE_CYCLES - 1);
						end
					end else if (l_r.nbytes == 3'h4 && boundary && c_r.latch
						&& l_r.data[LOCK_DATA_BIT] && !c_r.lock) begin
						c_nxt.pend_lock = 1'b1;
						c_nxt.busy      = 1'b1;
						c_nxt.timer     = 16'(WRITE_CYCLES - 1);
					end
				end
				default: begin
					c_nxt.latch = c_r.latch;
				end
			endcase
		end
		// View frozen while selected so the link never sees it move
		if (c_r.cs_s2) begin
			c_nxt.view = c_nxt.busy ? STATUS_BUSY
				: {c_nxt.arm, 3'b000, c_nxt.sel_hi, c_nxt.sel_lo, c_nxt.latch, 1'b0};
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			c_r <= CORE_RESET;
		end else begin
			c_r <= c_nxt;
		end
	end

	assign o_status          = c_r.view;
	assign o_hw_protect      = c_r.hw_protect;
	assign o_array_write_go  = c_r.array_go;
	assign o_idpage_write_go = c_r.id_go;
	assign o_write_addr      = c_r.wr_addr;

endmodule : sesao_top

/* core/sesao_pkg.sv */
// Constants, types and decode helpers for the serial EEPROM status and opcode block
package sesao_pkg;

	localparam int unsigned CLK_PERIOD_NS      = 100;
	localparam int unsigned T_WRITE_CYCLE_NS   = 5_000_000;
	localparam int unsigned WRITE_CYCLE_CYCLES = T_WRITE_CYCLE_NS / CLK_PERIOD_NS;

	localparam int unsigned ST_BUSY_BIT    = 0;
	localparam int unsigned ST_LATCH_BIT   = 1;
	localparam int unsigned ST_SEL_LO_BIT  = 2;
	localparam int unsigned ST_SEL_HI_BIT  = 3;
	localparam int unsigned ST_ARM_BIT     = 7;
	localparam logic [7:0]  STATUS_RESET   = 8'h00;
	localparam logic [7:0]  STATUS_BUSY    = 8'hFF;
	localparam logic [7:0]  READ_FILL      = 8'hFF;

	localparam logic [7:0]  OP_MASK              = 8'hF7;
	localparam logic [7:0]  OP_SET_WRITE_LATCH   = 8'h06;
	localparam logic [7:0]  OP_CLEAR_WRITE_LATCH = 8'h04;
	localparam logic [7:0]  OP_READ_STATUS       = 8'h05;
	localparam logic [7:0]  OP_WRITE_STATUS      = 8'h01;
	localparam logic [7:0]  OP_READ_ARRAY        = 8'h03;
	localparam logic [7:0]  OP_WRITE_ARRAY       = 8'h02;
	localparam logic [7:0]  OP_READ_IDPAGE       = 8'h83;
	localparam logic [7:0]  OP_WRITE_IDPAGE      = 8'h82;

	localparam int unsigned ADDR_SEL_BIT  = 10;
	localparam int unsigned LOCK_DATA_BIT = 1;
	localparam logic [13:0] PROT_QUARTER_BASE = 14'h3000;
	localparam logic [13:0] PROT_HALF_BASE    = 14'h2000;

	typedef enum logic [3:0] {
		OPC_INVALID, OPC_SET_WL, OPC_CLR_WL, OPC_RD_ST, OPC_WR_ST,
		OPC_RD_ARR, OPC_WR_ARR, OPC_RD_ID, OPC_WR_ID
	} sesao_op_e;

	typedef enum logic [1:0] {
		LNK_OPCODE = 2'b00,
		LNK_ADDR   = 2'b01,
		LNK_DATA   = 2'b11,
		LNK_IGNORE = 2'b10
	} sesao_lnk_e;

	typedef struct packed {
		sesao_lnk_e  state;
		logic [2:0]  bitph;
		logic [2:0]  nbytes;
		logic [7:0]  opcode;
		logic [15:0] addr;
		logic [7:0]  data;
	} sesao_link_s;

	typedef struct packed {
		logic        cs_s1;
		logic        cs_s2;
		logic        cs_s3;
		logic        wp_s1;
		logic        wp_s2;
		logic        busy;
		logic [15:0] timer;
		logic        latch;
		logic        sel_lo;
		logic        sel_hi;
		logic        arm;
		logic        lock;
		logic        pend_status;
		logic        pend_lock;
		logic [7:0]  new_status;
		logic [7:0]  view;
		logic        hw_protect;
		logic        array_go;
		logic        id_go;
		logic [15:0] wr_addr;
	} sesao_core_s;

	localparam sesao_core_s CORE_RESET = '{
		cs_s1: 1'b1, cs_s2: 1'b1, cs_s3: 1'b1, wp_s1: 1'b1, wp_s2: 1'b1,
		timer: 16'h0000, new_status: STATUS_RESET, view: STATUS_RESET,
		wr_addr: 16'h0000, default: 1'b0
	};

	function automatic sesao_op_e sesao_decode(input logic [7:0] op);
		logic [7:0] m;
		m = op & OP_MASK;
		case (m)
			OP_SET_WRITE_LATCH:   sesao_decode = OPC_SET_WL;
			OP_CLEAR_WRITE_LATCH: sesao_decode = OPC_CLR_WL;
			OP_READ_STATUS:       sesao_decode = OPC_RD_ST;
			OP_WRITE_STATUS:      sesao_decode = OPC_WR_ST;
			OP_READ_ARRAY:        sesao_decode = OPC_RD_ARR;
			OP_WRITE_ARRAY:       sesao_decode = OPC_WR_ARR;
			OP_READ_IDPAGE:       sesao_decode = OPC_RD_ID;
			OP_WRITE_IDPAGE:      sesao_decode = OPC_WR_ID;
			default:              sesao_decode = OPC_INVALID;
		endcase
	endfunction : sesao_decode

	function automatic logic sesao_prot_hit(input logic [1:0] sel, input logic [13:0] a);
		case (sel)
			2'b01:   sesao_prot_hit = (a >= PROT_QUARTER_BASE);
			2'b10:   sesao_prot_hit = (a >= PROT_HALF_BASE);
			2'b11:   sesao_prot_hit = 1'b1;
			default: sesao_prot_hit = 1'b0;
		endcase
	endfunction : sesao_prot_hit

endpackage : sesao_pkg

/* testbench/sesao_props.sv */
// Checker for status view, protection and write-start outputs
module sesao_props
	import sesao_pkg::*;
#(
	parameter int unsigned WRITE_CYCLES = 20
) (
	input wire logic       i_clk,
	input wire logic       i_reset,
	input wire logic       i_cs_n,
	input wire logic       i_protect_pin_n,
	input wire logic       o_so_oe,
	input wire logic [7:0] o_status,
	input wire logic       o_hw_protect,
	input wire logic       o_array_write_go,
	input wire logic       o_idpage_write_go
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [15:0] busy_cnt_r;
	always_ff @(posedge i_clk) begin
		if (i_reset || !o_status[0])
			busy_cnt_r <= 16'h0000;
		else
			busy_cnt_r <= busy_cnt_r + 16'h0001;
	end
	sequence pin_high_run;
		i_protect_pin_n [*5];
	endsequence
	sequence write_start;
		o_array_write_go || o_idpage_write_go;
	endsequence
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset);
	busy_ones_a: assert property (o_status[0] |-> o_status == STATUS_BUSY)
		else $error("status not all ones while busy");
	dont_care_a: assert property (!o_status[0] |-> o_status[6:4] == 3'h0)
		else $error("unstored status bits not zero");
	hw_off_a: assert property (pin_high_run |-> !o_hw_protect)
		else $error("hardware protect with pin high");
	go_busy_a: assert property (write_start |-> ##[1:2] o_status == STATUS_BUSY)
		else $error("write start without busy");
	array_pulse_a: assert property (o_array_write_go |=> !o_array_write_go)
		else $error("array start longer than one cycle");
	id_pulse_a: assert property (o_idpage_write_go |=> !o_idpage_write_go)
		else $error("id start longer than one cycle");
	oe_idle_a: assert property (i_cs_n |-> !o_so_oe)
		else $error("output enabled while deselected");
	busy_len_a: assert property ($fell(o_status[0]) |->
		busy_cnt_r + 2 >= WRITE_CYCLES && busy_cnt_r <= WRITE_CYCLES + 4)
		else $error("busy length wrong");
endmodule : sesao_props

bind sesao_top sesao_props #(.WRITE_CYCLES(WRITE_CYCLES)) props_u (
	.i_clk(i_clk), .i_reset(i_reset), .i_cs_n(i_cs_n),
	.i_protect_pin_n(i_protect_pin_n), .o_so_oe(o_so_oe), .o_status(o_status),
	.o_hw_protect(o_hw_protect), .o_array_write_go(o_array_write_go),
	.o_idpage_write_go(o_idpage_write_go));

/* testbench/sesao_spi_ctl.sv */
// Behavioural serial controller that frames transfers towards the device
module sesao_spi_ctl (
	output logic      o_sck,
	output logic      o_cs_n,
	output logic      o_si,
	input  wire logic i_so
);
	timeunit 1ns;
	timeprecision 100ps;
	// Select rises once after time zero so the frame flag and output flops start known
	initial begin
		o_sck = 1'b0;
		o_cs_n = 1'b0;
		o_si = 1'b1;
		#1 o_cs_n = 1'b1;
	end
	// Clock stands low between frames; the 7 ns offset keeps edges off the system clock
	task automatic xfer(input logic [31:0] d, input int n, output logic [7:0] q);
		q = 8'h00;
		#7;
		o_cs_n = 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			o_si = d[i];
			#32 o_sck = 1'b1;
			q = {q[6:0], i_so};
			#32 o_sck = 1'b0;
		end
		#10 o_cs_n = 1'b1;
		o_si = ~o_si;
		#500;
	endtask : xfer
endmodule : sesao_spi_ctl

/* testbench/sesao_top_tb.sv */
// Self-checking bench for the serial EEPROM status and opcode block
module sesao_top_tb
	import sesao_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	// Long enough that a frame and a status poll both fit inside one busy period
	localparam int unsigned WC = 60;
	logic        i_clk = 1'b0;
	logic        i_reset = 1'b1;
	logic        pin_n = 1'b1;
	logic        sck, cs_n, si, so, so_oe, hw_prot, arr_go, id_go;
	logic [7:0]  status, q;
	logic [7:0]  lfsr_r = 8'h45;
	logic [15:0] waddr, a;
	logic [15:0] aw_tab [3] = '{16'h2FFF, 16'h3000, 16'h1000};
	logic [16:0] exp_q [$];
	int          err_count = 0;
	int          n_checks = 0;
	int          cyc = 0;
	always #50 i_clk = ~i_clk;
	sesao_top #(.WRITE_CYCLES(WC)) dut_u (.i_clk(i_clk), .i_reset(i_reset), .i_sck(sck),
		.i_cs_n(cs_n), .i_si(si), .i_protect_pin_n(pin_n), .o_so(so), .o_so_oe(so_oe),
		.o_status(status), .o_hw_protect(hw_prot), .o_array_write_go(arr_go),
		.o_idpage_write_go(id_go), .o_write_addr(waddr));
	// Released output line is pulled high
	sesao_spi_ctl ctl_u (.o_sck(sck), .o_cs_n(cs_n), .o_si(si), .i_so(so_oe ? so : 1'b1));
	task automatic check(input logic [16:0] seen, input logic [16:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : end_of_test
	function automatic logic [7:0] lfsr_next(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction : lfsr_next
	task automatic cmd(input logic [31:0] d, input int n);
		ctl_u.xfer(d, n, q);
	endtask : cmd
	// Both the shifted byte and the parallel view must agree
	task automatic rd_st(input logic [7:0] e);
		ctl_u.xfer({16'h0000, OP_READ_STATUS, 8'h00}, 16, q);
		check({9'h000, q}, {9'h000, e});
		check({9'h000, status}, {9'h000, e});
	endtask : rd_st
	task automatic wait_idle();
		for (int i = 0; i < 100 && status[0] !== 1'b0; i++)
			@(negedge i_clk);
	endtask : wait_idle
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			end_of_test();
		end
	end
	// Every write start is matched against the oldest noted address
	always @(negedge i_clk) begin
		if (arr_go === 1'b1 || id_go === 1'b1)
			check({id_go, waddr}, exp_q.size() > 0 ? exp_q.pop_front() : 17'h1FFFF);
	end
	initial begin
		repeat (3) @(negedge i_clk);
		i_reset = 1'b0;
		@(negedge i_clk);
		rd_st(STATUS_RESET);
		cmd(32'h0E, 8);
		rd_st(8'h02);
		cmd(32'h0C, 8);
		rd_st(8'h00);
		cmd(32'h018C, 16);
		rd_st(8'h00);
		$display("latch tests done");
		cmd(32'h06, 8);
		cmd(32'h01FC, 16);
		cmd(32'h06, 8);
		cmd({OP_WRITE_ARRAY, 16'h0100, 8'h5A}, 32);
		rd_st(STATUS_BUSY);
		wait_idle();
		rd_st(8'h8C);
		@(negedge i_clk);
		pin_n = 1'b0;
		repeat (5) @(negedge i_clk);
		check({16'h0000, hw_prot}, 17'h00001);
		cmd(32'h06, 8);
		cmd(32'h0100, 16);
		rd_st(8'h8E);
		cmd({OP_WRITE_ARRAY, 16'h0000, 8'hAA}, 32);
		@(negedge i_clk);
		pin_n = 1'b1;
		repeat (5) @(negedge i_clk);
		cmd(32'h0104, 16);
		wait_idle();
		rd_st(8'h04);
		$display("status write tests done");
		for (int k = 0; k < 3; k++) begin
			lfsr_r = lfsr_next(lfsr_r);
			a = (k == 2) ? {4'h1, lfsr_r, 4'h0} : aw_tab[k];
			cmd(32'h06, 8);
			if (k != 1)
				exp_q.push_back({1'b0, a});
			cmd({OP_WRITE_ARRAY, a, lfsr_r}, 32);
			wait_idle();
		end
		cmd(32'h06, 8);
		exp_q.push_back(17'h10000);
		cmd({OP_WRITE_IDPAGE, 16'h0000, 8'h55}, 32);
		wait_idle();
		ctl_u.xfer({OP_READ_ARRAY, 16'h0000, 8'h00}, 32, q);
		check({9'h000, q}, {9'h000, READ_FILL});
		ctl_u.xfer({OP_WRITE_IDPAGE, 16'h0400, 8'h00}, 32, q);
		check({9'h000, q}, 17'h00000);
		cmd(32'h06, 8);
		cmd({OP_WRITE_IDPAGE, 16'h0400, 8'h02}, 32);
		wait_idle();
		ctl_u.xfer({OP_WRITE_IDPAGE, 16'h0400, 8'h00}, 32, q);
		check({9'h000, q}, 17'h00001);
		cmd(32'h06, 8);
		cmd({OP_WRITE_IDPAGE, 16'h0000, 8'h66}, 32);
		wait_idle();
		$display("lock tests done");
		cmd(32'h06, 8);
		cmd(32'h47123456, 32);
		rd_st(8'h06);
		check({16'h0000, exp_q.size() == 0}, 17'h00001);
		$display("write start tests done");
		end_of_test();
	end
endmodule : sesao_top_tb
